// File: verilog/rail_control_pg_delay_regs.sv
`timescale 1ns/1ns
// Voltage code, converter control and power-good delay registers
module rail_control_pg_delay_regs import rail_pkg::*; #(
  parameter int CYCLES_MS = CYCLES_PER_MS
) (
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata_q,
  // Factory configuration reset values
  input wire logic [7:0] otp_aux3_voltage,
  input wire logic [5:0] otp_converter_ctrl,
  input wire logic [7:0] otp_pg_delay,
  // Aux regulator 3
  input wire logic aux_reg3_sleep,
  output logic [3:0] aux_reg3_level_q,
  output logic [3:0] aux_reg3_sleep_level_q,
  output logic [3:0] aux_reg3_normal_level_q,
  // Step-down converters, index 0 is converter 1
  input wire logic [2:0] stepdown_pin_req,
  input wire logic [2:0] stepdown_host_on,
  output logic [2:0] stepdown_op_select_q,
  output logic [2:0] stepdown_enable_q,
  // General outputs, index 0 out1, 1 out2, 2 out4
  input wire out_use_e out_use_1,
  input wire out_use_e out_use_2,
  input wire out_use_e out_use_4,
  input wire logic [2:0] host_level,
  input wire logic [2:0] rails_in_regulation,
  input wire logic [2:0] level_shift_in,
  input wire logic out2_feeds_termination,
  output logic general_output_1_q,
  output logic general_output_2_q,
  output logic general_output_4_q,
  output logic memory_termination_regulator_en_q
);
  // Stored register fields
  logic [7:0] aux3_volt_q; // Sleep and normal codes
  logic [5:0] conv_ctrl_q; // Op select and kill bits only
  logic [7:0] pg_delay_q; // Three delay fields

  // Two-flop synchronisers for asynchronous status
  logic [2:0] rails_meta_q;
  logic [2:0] rails_sync_q;
  logic [2:0] shift_meta_q;
  logic [2:0] shift_sync_q;

  // Address decode
  wire logic hit_aux3;
  wire logic hit_ctrl;
  wire logic hit_delay;
  assign hit_aux3 = (reg_addr == AUX3_VOLT_ADDR);
  assign hit_ctrl = (reg_addr == CONV_CTRL_ADDR);
  assign hit_delay = (reg_addr == PG_DELAY_ADDR);

  // Read selection; control bits 7:6 are not stored
  wire logic [7:0] rd_mux;
  assign rd_mux = hit_aux3 ? aux3_volt_q :
                  hit_ctrl ? {2'b00, conv_ctrl_q} :
                  hit_delay ? pg_delay_q : UNMAPPED_READ;

  // Field views
  wire logic [3:0] sleep_code;
  wire logic [3:0] normal_code;
  wire logic [2:0] op_sel;
  wire logic [2:0] kill_n;
  assign sleep_code = aux3_volt_q[AUX3_SLEEP_LSB +: 4];
  assign normal_code = aux3_volt_q[AUX3_NORMAL_LSB +: 4];
  assign op_sel = conv_ctrl_q[OP_SELECT_LSB +: 3];
  assign kill_n = conv_ctrl_q[KILL_LSB +: 3];

  // Applied aux regulator code by mode
  wire logic [3:0] aux_level_d;
  assign aux_level_d = aux_reg3_sleep ? sleep_code : normal_code;

  // Converter enable: kill wins over pins and host override
  wire logic [2:0] enable_d;
  assign enable_d = kill_n & (stepdown_pin_req | stepdown_host_on);

  // Delay codes per output; out1 field is two bits wide
  wire logic [2:0] code_out1;
  wire logic [2:0] code_out2;
  wire logic [2:0] code_out4;
  assign code_out1 = {1'b0, pg_delay_q[OUT1_DLY_LSB +: 2]};
  assign code_out2 = pg_delay_q[OUT2_DLY_LSB +: 3];
  assign code_out4 = pg_delay_q[OUT4_DLY_LSB +: 3];

  // Register writes; reset loads factory values
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Factory values
      aux3_volt_q <= otp_aux3_voltage;
      conv_ctrl_q <= otp_converter_ctrl;
      pg_delay_q <= otp_pg_delay;
    end else if (reg_we) begin
      if (hit_aux3) begin
        aux3_volt_q <= reg_wdata;
      end
      if (hit_ctrl) begin
        // Upper two bits dropped
        conv_ctrl_q <= reg_wdata[5:0];
      end
      if (hit_delay) begin
        pg_delay_q <= reg_wdata;
      end
    end
  end

  // Read data register, loaded on a read strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_re) begin
      reg_rdata_q <= rd_mux;
    end
  end

  // Synchronise rail status and level inputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rails_meta_q <= 3'h0;
      rails_sync_q <= 3'h0;
      shift_meta_q <= 3'h0;
      shift_sync_q <= 3'h0;
    end else begin
      rails_meta_q <= rails_in_regulation;
      rails_sync_q <= rails_meta_q;
      shift_meta_q <= level_shift_in;
      shift_sync_q <= shift_meta_q;
    end
  end

  // Regulator and converter outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aux_reg3_level_q <= 4'h0;
      aux_reg3_sleep_level_q <= 4'h0;
      aux_reg3_normal_level_q <= 4'h0;
      stepdown_op_select_q <= 3'h0;
      stepdown_enable_q <= 3'h0;
    end else begin
      aux_reg3_level_q <= aux_level_d;
      aux_reg3_sleep_level_q <= sleep_code;
      aux_reg3_normal_level_q <= normal_code;
      stepdown_op_select_q <= op_sel;
      stepdown_enable_q <= enable_d;
    end
  end

  // Per-output use and delay code lists
  out_use_e use_w [3];
  logic [2:0] code_w [3];
  assign use_w[0] = out_use_1;
  assign use_w[1] = out_use_2;
  assign use_w[2] = out_use_4;
  assign code_w[0] = code_out1;
  assign code_w[1] = code_out2;
  assign code_w[2] = code_out4;

  // Delay timers, one per general output
  delay_if dl [3] ();
  logic [2:0] good_w; // Delayed good per output
  logic [2:0] out_d; // Next pin level per output
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_out
      // Level shift times the level input, otherwise grouped rails
      assign dl[gi].trigger = (use_w[gi] == OUT_LEVEL_SHIFT) ? shift_sync_q[gi] :
                              rails_sync_q[gi];
      assign dl[gi].code = code_w[gi];
      assign good_w[gi] = dl[gi].good;
      // Host use bypasses the timer
      assign out_d[gi] = (use_w[gi] == OUT_HOST) ? host_level[gi] : good_w[gi];
      pg_delay_timer #(
        .CYCLES_MS(CYCLES_MS)
      ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .dl(dl[gi])
      );
    end
  endgenerate

  // Termination enable keeps the out2 delay in every use
  wire logic vtt_en_d;
  assign vtt_en_d = out2_feeds_termination & good_w[1];

  // General output pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      general_output_1_q <= 1'b0;
      general_output_2_q <= 1'b0;
      general_output_4_q <= 1'b0;
      memory_termination_regulator_en_q <= 1'b0;
    end else begin
      general_output_1_q <= out_d[0];
      general_output_2_q <= out_d[1];
      general_output_4_q <= out_d[2];
      memory_termination_regulator_en_q <= vtt_en_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Write followed by read of the same register
  sequence ctrl_write_s;
    reg_we && hit_ctrl;
  endsequence

  sequence ctrl_read_s;
    reg_re && hit_ctrl;
  endsequence

  reserved_zero_a: assert property (ctrl_write_s ##1 ctrl_read_s |=>
      reg_rdata_q == {2'b00, $past(reg_wdata[5:0], 2)})
    else $error("control readback wrong");
  kill_wins_a: assert property (kill_n[0] == 1'b0 |=> !stepdown_enable_q[0])
    else $error("killed converter enabled");
  override_on_a: assert property (kill_n[1] && stepdown_host_on[1] |=>
      stepdown_enable_q[1])
    else $error("override did not force on");
  mode_select_a: assert property (ctrl_write_s |=> ##1
      stepdown_op_select_q == $past(reg_wdata[5:3], 2))
    else $error("op select not applied");
  sleep_level_a: assert property (aux_reg3_sleep |=>
      aux_reg3_level_q == $past(aux3_volt_q[7:4]))
    else $error("sleep code not applied");
  normal_level_a: assert property (!aux_reg3_sleep |=>
      aux_reg3_level_q == $past(aux3_volt_q[3:0]))
    else $error("normal code not applied");
  host_bypass_a: assert property (use_w[2] == OUT_HOST |=>
      general_output_4_q == $past(host_level[2]))
    else $error("host output not followed");
  term_enable_a: assert property (out2_feeds_termination && !rails_sync_q[1] |=> ##1
      !memory_termination_regulator_en_q)
    else $error("termination enabled without rails");
  good_needs_rails_a: assert property (use_w[0] == OUT_POWER_GOOD && !rails_sync_q[0]
      ##1 use_w[0] == OUT_POWER_GOOD |=> !general_output_1_q)
    else $error("good without rails");
endmodule

// File: verilog/rail_pkg.sv
package rail_pkg;
  // Register offsets
  localparam logic [7:0] AUX3_VOLT_ADDR = 8'h9B;
  localparam logic [7:0] CONV_CTRL_ADDR = 8'h9C;
  localparam logic [7:0] PG_DELAY_ADDR = 8'h9D;
  // Field positions
  localparam int AUX3_SLEEP_LSB = 4;
  localparam int AUX3_NORMAL_LSB = 0;
  localparam int OP_SELECT_LSB = 3;
  localparam int KILL_LSB = 0;
  localparam int OUT2_DLY_LSB = 5;
  localparam int OUT4_DLY_LSB = 2;
  localparam int OUT1_DLY_LSB = 0;
  // Value read from unmapped offsets
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Delay time base
  localparam int CLK_PERIOD_NS = 40;
  localparam int DELAY_UNIT_NS = 1_000_000;
  localparam int CYCLES_PER_MS = DELAY_UNIT_NS / CLK_PERIOD_NS;
  // Nominal delays in ms per code
  localparam logic [6:0] DLY_MS_0 = 7'h00;
  localparam logic [6:0] DLY_MS_1 = 7'h05;
  localparam logic [6:0] DLY_MS_2 = 7'h0A;
  localparam logic [6:0] DLY_MS_3 = 7'h0F;
  localparam logic [6:0] DLY_MS_4 = 7'h14;
  localparam logic [6:0] DLY_MS_5 = 7'h32;
  localparam logic [6:0] DLY_MS_6 = 7'h4B;
  localparam logic [6:0] DLY_MS_7 = 7'h64;

  // Use of a general output
  typedef enum logic [1:0] {
    OUT_POWER_GOOD = 2'b00,
    OUT_LEVEL_SHIFT = 2'b01,
    OUT_HOST = 2'b10
  } out_use_e;

  // Delay timer states
  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_COUNT = 2'b01,
    T_GOOD = 2'b10
  } timer_state_e;

  // Code to nominal delay in ms
  function automatic logic [6:0] delay_ms(input logic [2:0] code);
    case (code)
      3'h0: delay_ms = DLY_MS_0;
      3'h1: delay_ms = DLY_MS_1;
      3'h2: delay_ms = DLY_MS_2;
      3'h3: delay_ms = DLY_MS_3;
      3'h4: delay_ms = DLY_MS_4;
      3'h5: delay_ms = DLY_MS_5;
      3'h6: delay_ms = DLY_MS_6;
      default: delay_ms = DLY_MS_7;
    endcase
  endfunction
endpackage

// File: verilog/delay_if.sv
`timescale 1ns/1ns
// Link between output logic and one delay timer
interface delay_if;
  logic trigger; // Rails in regulation or level input high
  logic [2:0] code; // Delay code
  logic good; // Delayed good level
  modport ctrl(output trigger, output code, input good);
  modport timer(input trigger, input code, output good);
endinterface

// File: verilog/pg_delay_timer.sv
`timescale 1ns/1ns
// Holds good low until trigger has stood for the coded delay
module pg_delay_timer import rail_pkg::*; #(
  parameter int CYCLES_MS = CYCLES_PER_MS
) (
  input wire logic clk,
  input wire logic rst_n,
  delay_if.timer dl
);
  timer_state_e state_q, state_d; // Timer state
  logic [15:0] cyc_q, cyc_d; // Cycles within current ms
  logic [6:0] ms_q, ms_d; // Whole ms elapsed
  wire logic [6:0] target_ms; // Nominal delay
  wire logic ms_wrap; // Last cycle of a ms
  wire logic [6:0] ms_inc; // Ms count after wrap

  assign target_ms = delay_ms(dl.code);
  assign ms_wrap = (cyc_q == 16'(CYCLES_MS - 1));
  assign ms_inc = ms_q + 7'h01;
  assign dl.good = (state_q == T_GOOD);

  // Next state; count restarts whenever trigger drops
  always_comb begin
    state_d = state_q;
    cyc_d = cyc_q;
    ms_d = ms_q;
    case (state_q)
      T_IDLE: begin
        cyc_d = 16'h0000;
        ms_d = 7'h00;
        // Timing starts at trigger rise
        if (dl.trigger) begin
          state_d = (target_ms == 7'h00) ? T_GOOD : T_COUNT;
        end
      end
      T_COUNT: begin
        if (!dl.trigger) begin
          state_d = T_IDLE;
        end else if (ms_wrap) begin
          cyc_d = 16'h0000;
          ms_d = ms_inc;
          // Exact nominal count, tolerance is analog only
          if (ms_inc >= target_ms) begin
            state_d = T_GOOD;
          end
        end else begin
          cyc_d = cyc_q + 16'h0001;
        end
      end
      T_GOOD: begin
        if (!dl.trigger) begin
          state_d = T_IDLE;
        end
      end
      default: state_d = T_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= T_IDLE;
      cyc_q <= 16'h0000;
      ms_q <= 7'h00;
    end else begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      ms_q <= ms_d;
    end
  end

  // Cycles the trigger has stood, for checking only
  logic [23:0] held_q;
  always_ff @(posedge clk) begin
    if (!rst_n || !dl.trigger) begin
      held_q <= 24'h000000;
    end else begin
      held_q <= held_q + 24'h000001;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence trig_fall_s;
    $fell(dl.trigger);
  endsequence

  good_drop_a: assert property (trig_fall_s |=> !dl.good)
    else $error("good stayed after trigger fell");
  // Held count already includes the edge that first saw the trigger high
  good_time_a: assert property ($rose(dl.good) |->
      held_q == 24'(target_ms) * 24'(CYCLES_MS) + 24'h000001)
    else $error("good rose at wrong delay");
  zero_delay_a: assert property ($rose(dl.trigger) && target_ms == 7'h00 |=> dl.good)
    else $error("zero delay not immediate");
endmodule

// File: tb/reg_host_model.sv
`timescale 1ns/1ns
// Host side of the register port, one strobe per access
module reg_host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  output logic reg_re
);
  // Idle values at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
  end

  // Write: one strobe cycle, then released lines show the inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // Read: one strobe cycle
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    reg_addr <= ~a;
  endtask
endmodule

// File: tb/rail_control_pg_delay_regs_bench.sv
`timescale 1ns/1ns
// Self-checking bench for the rail register slice
module rail_control_pg_delay_regs_bench import rail_pkg::*; ;
  localparam int CYC = 10; // Shortened cycles per ms
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
  logic reg_we, reg_re;
  logic [7:0] otp_a, otp_d, v;
  logic [5:0] otp_c;
  logic sleep = 1'b0;
  logic [3:0] lvl, slp_lvl, nrm_lvl;
  logic [2:0] pin_req = 3'h0, host_on = 3'h0, op_sel, en;
  out_use_e use1 = OUT_POWER_GOOD, use2 = OUT_POWER_GOOD, use4 = OUT_POWER_GOOD;
  logic [2:0] host_level = 3'h0, rails = 3'h0, lvl_in = 3'h0;
  logic feeds = 1'b0;
  logic o1, o2, o4, term;
  logic [7:0] exp_q[$]; // Expected read data, oldest first
  logic re_seen = 1'b0;
  logic [6:0] tab[8] = '{7'h00, 7'h05, 7'h0A, 7'h0F, 7'h14, 7'h32, 7'h4B, 7'h64};
  int err_count = 0;
  int compares = 0;
  int seed = 11;

  // Clock at 25 MHz
  always #20 clk = ~clk;

  reg_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re));

  rail_control_pg_delay_regs #(.CYCLES_MS(CYC)) DUT (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata_q(reg_rdata_q), .otp_aux3_voltage(otp_a), .otp_converter_ctrl(otp_c),
    .otp_pg_delay(otp_d), .aux_reg3_sleep(sleep), .aux_reg3_level_q(lvl),
    .aux_reg3_sleep_level_q(slp_lvl), .aux_reg3_normal_level_q(nrm_lvl),
    .stepdown_pin_req(pin_req), .stepdown_host_on(host_on),
    .stepdown_op_select_q(op_sel), .stepdown_enable_q(en), .out_use_1(use1),
    .out_use_2(use2), .out_use_4(use4), .host_level(host_level),
    .rails_in_regulation(rails), .level_shift_in(lvl_in),
    .out2_feeds_termination(feeds), .general_output_1_q(o1),
    .general_output_2_q(o2), .general_output_4_q(o4),
    .memory_termination_regulator_en_q(term));

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Read data appears one cycle after the strobe; take oldest note
  always @(posedge clk) begin
    if (re_seen) begin
      check(reg_rdata_q, exp_q.pop_front());
    end
    re_seen <= reg_re;
  end

  // Note the expectation, then read
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask

  // Pin level of general output by index
  function automatic logic pin(input int i);
    pin = (i == 0) ? o1 : (i == 1) ? o2 : o4;
  endfunction

  // Raise the rails of one output and time its good level
  task automatic dly(input int i, input logic [6:0] ms);
    int n;
    int lo;
    int hi;
    n = 0;
    lo = ms * CYC * 9 / 10;
    hi = ms * CYC * 11 / 10 + 5;
    @(posedge clk) rails <= 3'h0;
    repeat (6) @(posedge clk);
    check({7'h00, pin(i)}, 8'h00);
    rails[i] <= 1'b1;
    while (pin(i) !== 1'b1 && n < 1200) begin
      @(posedge clk);
      n++;
    end
    check({7'h00, n >= lo && n <= hi}, 8'h01);
  endtask

  // Hang guard
  initial begin
    #(40 * 40000);
    err_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    otp_a = $random(seed);
    otp_c = $random(seed);
    otp_d = $random(seed);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // Factory values, reserved bits, unmapped place
    rd_chk(AUX3_VOLT_ADDR, otp_a);
    rd_chk(CONV_CTRL_ADDR, {2'b00, otp_c});
    rd_chk(PG_DELAY_ADDR, otp_d);
    host.wr(8'h5A, 8'hFF);
    rd_chk(8'h5A, 8'h00);
    rd_chk(AUX3_VOLT_ADDR, otp_a);
    host.wr(CONV_CTRL_ADDR, 8'hFF);
    rd_chk(CONV_CTRL_ADDR, 8'h3F);
    // Converter mode and kill against pins and override
    repeat (8) begin
      v = $random(seed);
      @(posedge clk);
      pin_req <= $random(seed);
      host_on <= $random(seed);
      host.wr(CONV_CTRL_ADDR, v);
      repeat (3) @(posedge clk);
      #1;
      check({5'h00, op_sel}, {5'h00, v[5:3]});
      check({5'h00, en}, {5'h00, v[2:0] & (pin_req | host_on)});
    end
    // Aux regulator 3 codes in both modes
    v = $random(seed);
    host.wr(AUX3_VOLT_ADDR, v);
    rd_chk(AUX3_VOLT_ADDR, v);
    repeat (2) @(posedge clk);
    #1;
    check({slp_lvl, nrm_lvl}, v);
    check({4'h0, lvl}, {4'h0, v[3:0]});
    @(posedge clk) sleep <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check({4'h0, lvl}, {4'h0, v[7:4]});
    // Every delay code of every output
    for (int k = 0; k < 8; k++) begin
      host.wr(PG_DELAY_ADDR, {k[2:0], k[2:0], k[1:0]});
      dly(1, tab[k]);
      dly(2, tab[k]);
      if (k < 4) begin
        dly(0, tab[k]);
      end
    end
    // Host use ignores the delay, level shift follows its input
    host.wr(PG_DELAY_ADDR, 8'hFF);
    @(posedge clk);
    use1 <= OUT_HOST;
    use2 <= OUT_HOST;
    use4 <= OUT_HOST;
    rails <= 3'h7;
    host_level <= 3'h5;
    repeat (3) @(posedge clk);
    #1;
    check({5'h00, o4, o2, o1}, 8'h05);
    host.wr(PG_DELAY_ADDR, 8'h00);
    use1 <= OUT_LEVEL_SHIFT;
    use2 <= OUT_LEVEL_SHIFT;
    use4 <= OUT_LEVEL_SHIFT;
    rails <= 3'h0;
    lvl_in <= 3'h7;
    repeat (8) @(posedge clk);
    #1;
    check({5'h00, o4, o2, o1}, 8'h07);
    // Termination enable keeps the out2 delay under host use
    host.wr(PG_DELAY_ADDR, 8'h20);
    use2 <= OUT_HOST;
    host_level <= 3'h0;
    feeds <= 1'b1;
    repeat (6) @(posedge clk);
    rails[1] <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    check({6'h00, term, o2}, 8'h00);
    repeat (45) @(posedge clk);
    #1;
    check({6'h00, term, o2}, 8'h02);
    repeat (3) @(posedge clk);
    stop_test();
  end
endmodule
